// file: hw/rops_pkg.sv
// Package for the remappable output pin selection block.
// Assumes a 32-bit classic Wishbone slave with word-aligned registers.
package rops_pkg;

  // ==========================================================================
  // Register map
  // Word index of each output route register, pins 4/5 through 30/31
  localparam int RegCount = 14;
  localparam logic [3:0] IdxPins4_5 = 4'h0;
  localparam logic [3:0] IdxPins30_31 = 4'hD;
  // Byte address of the first register; byte address is four times the index
  localparam logic [7:0] BaseOffset = 8'h00;
  localparam int AddrWidth = 8;

  // ==========================================================================
  // Field layout
  localparam int SelWidth = 6;
  localparam int LowSelLsb = 0;
  localparam int HighSelLsb = 8;
  localparam logic [15:0] ImplMask = 16'h3F3F;
  localparam logic [15:0] RegReset = 16'h0000;

  // ==========================================================================
  // Pins and peripheral outputs
  localparam int FirstPin = 4;
  localparam int PinCount = 28;
  localparam int FuncCount = 64;
  // Pins without a pad on the smallest package
  localparam int SmallPkgPinA = 5;
  localparam int SmallPkgPinB = 15;
  localparam int SmallPkgPinC = 31;
  // Pin absent on the reduced-feature variant
  localparam int ReducedPin = 30;

  // ==========================================================================
  // Bus slave states
  typedef enum logic [0:0] {
    ROPS_IDLE = 1'b0,
    ROPS_ACK = 1'b1
  } rops_state_t;

endpackage : rops_pkg

// file: hw/rops_route_reg.sv
// One output route register: two 6-bit selectors serving a pin pair.
// Assumes writes are qualified by the bus slave one cycle before acknowledge.
`timescale 1ns/1ps
module rops_route_reg (
  input wire logic clock, // System clock
  input wire logic nrst, // Async reset, active low
  input wire logic wrEn, // Write strobe for this register
  input wire logic [3:0] sel, // Byte enables
  input wire logic [15:0] wrData, // Write data
  output logic [5:0] evenSel, // Selector of even pin
  output logic [5:0] oddSel // Selector of odd pin
);

  // ==========================================================================
  // Storage, byte-laned; unimplemented bits never stored
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      evenSel <= rops_pkg::RegReset[5:0];
    end else if (wrEn && sel[0]) begin
      evenSel <= wrData[5:0];
    end
  end

  // Upper selector in bits 13..8
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      oddSel <= rops_pkg::RegReset[13:8];
    end else if (wrEn && sel[1]) begin
      oddSel <= wrData[13:8];
    end
  end

endmodule : rops_route_reg

// file: hw/rops_pin_mux.sv
// One pin's output multiplexer: selects a peripheral output by number.
// Assumes function 0 means no peripheral; the port latch takes the pin.
`timescale 1ns/1ps
module rops_pin_mux (
  input wire logic clock, // System clock
  input wire logic nrst, // Async reset, active low
  input wire logic [5:0] selector, // Function number
  input wire logic present, // Pin has a pad
  input wire logic [63:0] funcOut, // Peripheral outputs by number
  input wire logic [63:0] funcValid, // Which numbers name a function
  output logic pinOut, // Routed value
  output logic pinOwned // Peripheral owns the pin
);

  // ==========================================================================
  // Registered selection
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      pinOut <= 1'b0;
      pinOwned <= 1'b0;
    end else begin
      pinOwned <= present && funcValid[selector];
      pinOut <= present && funcValid[selector] && funcOut[selector];
    end
  end

endmodule : rops_pin_mux

// file: hw/rops_top.sv
// Remappable output pin select: Wishbone register bank and pin muxes.
// Overview of operation
// - Selector value n routes peripheral output n
// - Bits 13..8 select the odd pin
// - Bits 5..0 select the even pin
// - Bits 15..14, 7..6 read zero, ignore writes
// - Selectors read back last written value
// - Small package: pins 5,15,31 drive nothing
// - Reduced variant: pin 30 drives nothing
// Assumes peripheral outputs arrive synchronous to clock.
`timescale 1ns/1ps
module rops_top (
  input wire logic clock, // System clock, 125 MHz
  input wire logic nrst, // Async reset, active low
  input wire logic wb_cyc_i, // Wishbone cycle
  input wire logic wb_stb_i, // Wishbone strobe
  input wire logic wb_we_i, // Write enable
  input wire logic [7:0] wb_adr_i, // Byte address
  input wire logic [3:0] wb_sel_i, // Byte enables
  input wire logic [31:0] wb_dat_i, // Write data
  output logic [31:0] wb_dat_o, // Read data
  output logic wb_ack_o, // Acknowledge
  output logic wb_err_o, // Unmapped address
  input wire logic smallPackage, // Part lacks pads for pins 5,15,31
  input wire logic reducedPart, // Part lacks pin 30
  input wire logic [63:0] funcOut, // Peripheral outputs by number
  input wire logic [63:0] funcValid, // Numbers that name a function
  output logic [27:0] pinOut, // Pad data, pins 4..31
  output logic [27:0] pinOwned // Peripheral owns pad, pins 4..31
);

  // ==========================================================================
  // Bus decode
  rops_pkg::rops_state_t state;
  logic [5:0] evenSel [rops_pkg::RegCount];
  logic [5:0] oddSel [rops_pkg::RegCount];
  logic [3:0] regIdx;
  logic hit;
  logic req;
  logic [27:0] present;
  logic [27:0] muxOut;
  logic [27:0] muxOwned;
  logic [15:0] readWord;

  assign req = wb_cyc_i && wb_stb_i && (state == rops_pkg::ROPS_IDLE);
  assign regIdx = wb_adr_i[5:2];
  assign hit = (wb_adr_i[1:0] == 2'h0) && (wb_adr_i[7:6] == rops_pkg::BaseOffset[7:6])
    && (regIdx <= rops_pkg::IdxPins30_31);

  // Read word assembly, unimplemented bits zero
  always_comb begin
    readWord = 16'h0000;
    for (int i = 0; i < rops_pkg::RegCount; i++) begin
      if (regIdx == 4'(i)) begin
        readWord = {2'h0, oddSel[i], 2'h0, evenSel[i]} & rops_pkg::ImplMask;
      end
    end
  end

  // Bus handshake: ack one cycle after request, then drop
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      state <= rops_pkg::ROPS_IDLE;
      wb_ack_o <= 1'b0;
      wb_err_o <= 1'b0;
    end else begin
      wb_ack_o <= req && hit;
      wb_err_o <= req && !hit;
      state <= req ? rops_pkg::ROPS_ACK : rops_pkg::ROPS_IDLE;
    end
  end

  // Read data captured with ack
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      wb_dat_o <= 32'h0000_0000;
    end else if (req && hit && !wb_we_i) begin
      wb_dat_o <= {16'h0000, readWord};
    end else begin
      wb_dat_o <= 32'h0000_0000;
    end
  end

  // ==========================================================================
  // Register bank
  genvar r;
  generate
    for (r = 0; r < rops_pkg::RegCount; r++) begin : g_reg
      rops_route_reg u_reg (
        .clock(clock),
        .nrst(nrst),
        .wrEn(req && hit && wb_we_i && (regIdx == 4'(r))),
        .sel(wb_sel_i),
        .wrData(wb_dat_i[15:0]),
        .evenSel(evenSel[r]),
        .oddSel(oddSel[r])
      );
    end
  endgenerate

  // ==========================================================================
  // Pad presence per part variant
  always_comb begin
    present = '1;
    if (smallPackage) begin
      present[rops_pkg::SmallPkgPinA - rops_pkg::FirstPin] = 1'b0;
      present[rops_pkg::SmallPkgPinB - rops_pkg::FirstPin] = 1'b0;
      present[rops_pkg::SmallPkgPinC - rops_pkg::FirstPin] = 1'b0;
    end
    if (reducedPart) begin
      present[rops_pkg::ReducedPin - rops_pkg::FirstPin] = 1'b0;
    end
  end

  // ==========================================================================
  // Pin multiplexers, even pin from low field, odd from high
  genvar p;
  generate
    for (p = 0; p < rops_pkg::PinCount; p++) begin : g_pin
      rops_pin_mux u_mux (
        .clock(clock),
        .nrst(nrst),
        .selector((p % 2 == 0) ? evenSel[p / 2] : oddSel[p / 2]),
        .present(present[p]),
        .funcOut(funcOut),
        .funcValid(funcValid),
        .pinOut(muxOut[p]),
        .pinOwned(muxOwned[p])
      );
    end
  endgenerate

  assign pinOut = muxOut;
  assign pinOwned = muxOwned;

  // ==========================================================================
  // Checks
  sequence s_write_pins4;
    req && hit && wb_we_i && regIdx == 4'h0 && wb_sel_i[0];
  endsequence

  a_write_readback: assert property (@(posedge clock) disable iff (!nrst)
    s_write_pins4 |=> evenSel[0] == $past(wb_dat_i[5:0]))
    else $error("even selector did not take write");

  a_ack_one_cycle: assert property (@(posedge clock) disable iff (!nrst)
    (req && hit) |=> wb_ack_o ##1 !wb_ack_o)
    else $error("ack not a single cycle");

  a_err_unmapped: assert property (@(posedge clock) disable iff (!nrst)
    (req && !hit) |=> wb_err_o && !wb_ack_o)
    else $error("unmapped access not refused");

  a_reserved_zero: assert property (@(posedge clock) disable iff (!nrst)
    wb_ack_o |-> (wb_dat_o & 32'hFFFF_C0C0) == 32'h0000_0000)
    else $error("reserved bits read nonzero");

  a_small_pkg: assert property (@(posedge clock) disable iff (!nrst)
    $past(smallPackage) |-> !pinOwned[1] && !pinOwned[11] && !pinOwned[27])
    else $error("absent pad driven on small package");

  a_reduced_pin: assert property (@(posedge clock) disable iff (!nrst)
    $past(reducedPart) |-> !pinOwned[26])
    else $error("pin 30 driven on reduced part");

  a_route_value: assert property (@(posedge clock) disable iff (!nrst)
    (present[0] && funcValid[evenSel[0]]) |=> pinOut[0] == $past(funcOut[evenSel[0]]))
    else $error("pin 4 not routed");

  a_odd_route: assert property (@(posedge clock) disable iff (!nrst)
    (present[1] && funcValid[oddSel[0]]) |=> pinOut[1] == $past(funcOut[oddSel[0]]))
    else $error("pin 5 not routed from upper field");

  a_unassigned: assert property (@(posedge clock) disable iff (!nrst)
    !funcValid[evenSel[2]] |=> !pinOwned[4] && !pinOut[4])
    else $error("unassigned selector drives pin 8");

  // ==========================================================================
  // Check helpers
  // Requests as the slave takes them, split by outcome
  logic wrTaken;
  logic rdTaken;
  logic errTaken;

  assign wrTaken = req && hit && wb_we_i;
  assign rdTaken = req && hit && !wb_we_i;
  assign errTaken = req && !hit;

  // Write to the upper field of the pins 4/5 register
  sequence s_write_pins5;
    wrTaken && regIdx == 4'h0 && wb_sel_i[1];
  endsequence

  // Read of the pins 4/5 register
  sequence s_read_pins4;
    rdTaken && regIdx == 4'h0;
  endsequence

  // Read of the pins 30/31 register
  sequence s_read_pins30;
    rdTaken && regIdx == 4'hD;
  endsequence

  // Acknowledge for one cycle, then quiet
  sequence s_ack_pulse;
    wb_ack_o ##1 !wb_ack_o;
  endsequence

  // Error for one cycle, never with acknowledge
  sequence s_err_pulse;
    (wb_err_o && !wb_ack_o) ##1 !wb_err_o;
  endsequence

  // ==========================================================================
  // Register writes, lane by lane, and refusals
  a_odd_write: assert property (@(posedge clock) disable iff (!nrst)
    s_write_pins5 |=> oddSel[0] == $past(wb_dat_i[13:8]))
    else $error("odd selector did not take write");

  a_even_hold: assert property (@(posedge clock) disable iff (!nrst)
    (wrTaken && regIdx == 4'h0 && !wb_sel_i[0]) |=> evenSel[0] == $past(evenSel[0]))
    else $error("even selector changed without its lane");

  a_odd_hold: assert property (@(posedge clock) disable iff (!nrst)
    (wrTaken && regIdx == 4'h0 && !wb_sel_i[1]) |=> oddSel[0] == $past(oddSel[0]))
    else $error("odd selector changed without its lane");

  a_refused_write: assert property (@(posedge clock) disable iff (!nrst)
    errTaken |=> evenSel[0] == $past(evenSel[0]) && oddSel[0] == $past(oddSel[0]))
    else $error("refused write changed a selector");

  a_err_pulse: assert property (@(posedge clock) disable iff (!nrst)
    errTaken |=> s_err_pulse)
    else $error("error not a single cycle");

  a_write_ack: assert property (@(posedge clock) disable iff (!nrst)
    wrTaken |=> s_ack_pulse)
    else $error("write ack not a single cycle");

  a_write_no_data: assert property (@(posedge clock) disable iff (!nrst)
    wrTaken |=> wb_dat_o == 32'h0000_0000)
    else $error("write returned read data");

  // ==========================================================================
  // Register reads
  a_read_first: assert property (@(posedge clock) disable iff (!nrst)
    s_read_pins4 |=> wb_dat_o ==
      {16'h0000, 2'h0, $past(oddSel[0]), 2'h0, $past(evenSel[0])})
    else $error("pins 4/5 register read wrong");

  a_read_last: assert property (@(posedge clock) disable iff (!nrst)
    s_read_pins30 |=> wb_dat_o ==
      {16'h0000, 2'h0, $past(oddSel[13]), 2'h0, $past(evenSel[13])})
    else $error("pins 30/31 register read wrong");

  a_dat_idle: assert property (@(posedge clock) disable iff (!nrst)
    !wb_ack_o |-> wb_dat_o == 32'h0000_0000)
    else $error("read data without ack");

  a_ack_err_excl: assert property (@(posedge clock) disable iff (!nrst)
    !(wb_ack_o && wb_err_o))
    else $error("ack and error together");

  // ==========================================================================
  // Pad outputs
  a_owned_data: assert property (@(posedge clock) disable iff (!nrst)
    (pinOut & ~pinOwned) == 28'h0000000)
    else $error("unowned pin carries data");

  a_unassigned_odd: assert property (@(posedge clock) disable iff (!nrst)
    !funcValid[oddSel[0]] |=> !pinOwned[1] && !pinOut[1])
    else $error("unassigned selector drives pin 5");

  a_top_odd: assert property (@(posedge clock) disable iff (!nrst)
    (present[27] && funcValid[oddSel[13]]) |=> pinOut[27] == $past(funcOut[oddSel[13]]))
    else $error("pin 31 not routed");

  a_top_even: assert property (@(posedge clock) disable iff (!nrst)
    (present[26] && funcValid[evenSel[13]]) |=> pinOut[26] == $past(funcOut[evenSel[13]]))
    else $error("pin 30 not routed");

  a_mid_even: assert property (@(posedge clock) disable iff (!nrst)
    (present[12] && funcValid[evenSel[6]]) |=> pinOut[12] == $past(funcOut[evenSel[6]]))
    else $error("pin 16 not routed");

  a_full_pkg: assert property (@(posedge clock) disable iff (!nrst)
    (!smallPackage && funcValid[oddSel[0]]) |=> pinOwned[1])
    else $error("pin 5 not driven on full package");

  a_reduced_keep: assert property (@(posedge clock) disable iff (!nrst)
    (reducedPart && !smallPackage && funcValid[oddSel[13]]) |=> pinOwned[27])
    else $error("pin 31 lost on reduced part");

  // Every pin without a pad stays quiet
  genvar q;
  generate
    for (q = 0; q < rops_pkg::PinCount; q++) begin : g_chk
      a_absent_pin: assert property (@(posedge clock) disable iff (!nrst)
        !present[q] |=> !pinOwned[q] && !pinOut[q])
        else $error("absent pin driven");
    end
  endgenerate

endmodule : rops_top

// file: sim/rops_periph_model.sv
// Peripheral output model: numbered peripheral outputs and their valid map.
// Assumes the system clock and reset of the pin select block.
`timescale 1ns/1ps
module rops_periph_model #(
  parameter logic [63:0] ValidMask = 64'h7FFF_FFFF_FFFF_FFFE
) (
  input wire logic clock, // System clock
  input wire logic nrst, // Async reset, active low
  output logic [63:0] funcOut, // Peripheral outputs by number
  output logic [63:0] funcValid // Numbers that name a function
);
  // ==========================================================================
  // Fixed map: number 0 and number 63 name no function
  assign funcValid = ValidMask;

  // Rotate and invert so routed values keep moving
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      funcOut <= 64'h0123_4567_89AB_CDEF;
    end else begin
      funcOut <= ~{funcOut[62:0], funcOut[63]};
    end
  end
endmodule : rops_periph_model

// file: sim/remap_output_pin_select_tb.sv
// Testbench for the remappable output pin select block.
// Assumes the design package is compiled first; Wishbone master is local.
`timescale 1ns/1ps
module remap_output_pin_select_tb;
  localparam logic [63:0] Valid = 64'h7FFF_FFFF_FFFF_FFFE;
  logic clock, nrst, cyc, stb, we, er, smallPackage, reducedPart;
  logic [7:0] adr;
  logic [3:0] sel;
  logic [31:0] dat, rd, wbDatO;
  logic wbAck, wbErr;
  logic [63:0] funcOut, funcValid, prev;
  logic [27:0] pinOut, pinOwned, expOwn, expDat;
  logic [5:0] selTab[28];
  int n_mismatch = 0;
  int checks = 0;

  rops_periph_model #(.ValidMask(Valid)) periph (.clock(clock), .nrst(nrst),
    .funcOut(funcOut), .funcValid(funcValid));
  rops_top dut (.clock(clock), .nrst(nrst), .wb_cyc_i(cyc), .wb_stb_i(stb),
    .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(dat), .wb_dat_o(wbDatO),
    .wb_ack_o(wbAck), .wb_err_o(wbErr), .smallPackage(smallPackage),
    .reducedPart(reducedPart), .funcOut(funcOut), .funcValid(funcValid),
    .pinOut(pinOut), .pinOwned(pinOwned));

  // ==========================================================================
  // Clock, 8 ns period
  initial begin
    clock = 1'b0;
    forever #4 clock = ~clock;
  end

  task automatic report_and_stop();
    if (n_mismatch == 0 && checks > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask : report_and_stop

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : chk

  // One classic Wishbone cycle, held until ack or err is sampled
  task automatic wb(input logic w, input logic [7:0] a, input logic [3:0] s,
                    input logic [31:0] d);
    int k;
    @(posedge clock);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    sel <= s;
    dat <= d;
    for (k = 0; k < 20; k++) begin
      @(posedge clock);
      if (wbAck === 1'b1 || wbErr === 1'b1) break;
    end
    if (k == 20) begin
      n_mismatch++;
      report_and_stop();
    end else begin
      rd = wbDatO;
      er = wbErr;
      cyc <= 1'b0;
      stb <= 1'b0;
      we <= 1'b0;
    end
  endtask : wb

  // Pad outputs against selectors, variant inputs and last peripheral values
  task automatic pin_check();
    int p;
    repeat (3) @(posedge clock);
    @(negedge clock);
    prev = funcOut;
    @(negedge clock);
    for (int k = 0; k < 28; k++) begin
      p = k + 4;
      expOwn[k] = Valid[selTab[k]] && !(smallPackage && (p == 5 || p == 15 || p == 31))
                  && !(reducedPart && p == 30);
      expDat[k] = expOwn[k] & prev[selTab[k]];
    end
    chk({4'h0, pinOwned}, {4'h0, expOwn});
    chk({4'h0, pinOut & expOwn}, {4'h0, expDat});
  endtask : pin_check

  // ==========================================================================
  // Main sequence
  initial begin
    {nrst, cyc, stb, we, smallPackage, reducedPart} = 6'h00;
    adr = 8'h00;
    sel = 4'h0;
    dat = 32'h0000_0000;
    for (int k = 0; k < 28; k++) selTab[k] = 6'(k + 4);
    repeat (4) @(posedge clock);
    nrst <= 1'b1;
    for (int i = 0; i < 14; i++) begin
      wb(1'b0, 8'(i * 4), 4'hF, 32'h0);
      chk(rd, 32'h0000_0000);
    end
    chk({4'h0, pinOwned}, 32'h0000_0000);
    // Every register: set the reserved bits too, read back selectors only
    for (int i = 0; i < 14; i++) begin
      wb(1'b1, 8'(i * 4), 4'hF, {16'hFFFF, 2'b11, selTab[2*i+1], 2'b11, selTab[2*i]});
      wb(1'b0, 8'(i * 4), 4'hF, 32'h0);
      chk(rd, {18'h0, selTab[2*i+1], 2'b00, selTab[2*i]});
    end
    pin_check();
    // Reduced part alone, then both variants together
    @(posedge clock);
    reducedPart <= 1'b1;
    pin_check();
    @(posedge clock);
    smallPackage <= 1'b1;
    pin_check();
    // Unmapped and misaligned addresses are refused
    wb(1'b1, 8'h38, 4'hF, 32'h0000_0101);
    chk({31'h0, er}, 32'h1);
    wb(1'b1, 8'h02, 4'hF, 32'h0000_0101);
    chk({31'h0, er}, 32'h1);
    wb(1'b0, 8'h00, 4'hF, 32'h0);
    chk(rd, 32'h0000_0504);
    // Selectors that name no function leave pins to the port
    selTab[0] = 6'h00;
    selTab[1] = 6'h3F;
    wb(1'b1, 8'h00, 4'hF, 32'h0000_3F00);
    pin_check();
    // Low byte enable alone changes only the even selector
    selTab[0] = 6'h0A;
    wb(1'b1, 8'h00, 4'h1, 32'h0000_0A0A);
    wb(1'b0, 8'h00, 4'hF, 32'h0);
    chk(rd, 32'h0000_3F0A);
    pin_check();
    // High byte enable alone changes only the odd selector
    selTab[1] = 6'h07;
    wb(1'b1, 8'h00, 4'h2, 32'h0000_0707);
    wb(1'b0, 8'h00, 4'hF, 32'h0);
    chk(rd, 32'h0000_070A);
    pin_check();
    report_and_stop();
  end
endmodule : remap_output_pin_select_tb
